// ==== isoio_regs.vh ====
`ifndef ISOIO_REGS_VH
`define ISOIO_REGS_VH

// word indices of the 32-bit words on the register bus
`define ISOIO_OFS_ID       4'h0
`define ISOIO_OFS_CTRL     4'h1
`define ISOIO_OFS_IN       4'h2
`define ISOIO_OFS_OUT      4'h3
`define ISOIO_ADDR_W       4

// control word fields (bits 15..8)
`define ISOIO_CTRL_FAULT_N  15
`define ISOIO_CTRL_OUT_ON   14
`define ISOIO_CTRL_IN_ON    13
`define ISOIO_CTRL_DLY_LSB  8
`define ISOIO_CTRL_RESET    8'h00

// arbitrary identity value, not tied to any part
`define ISOIO_ID_VALUE     16'h5a5a

// debounce times in ns and their cycle counts at 8 ns
`define ISOIO_CLK_NS       8
`define ISOIO_DLY1_NS      256000
`define ISOIO_DLY1_CYC     21'd32000
// code 7 holds off 64 times the base, so the counter needs 21 bits
`define ISOIO_DLY_CNT_W    21

`endif

// ==== isoio_latch.v ====
`default_nettype none

// 32-bit byte-enabled storage word, registered read data
module isoio_latch (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire [3:0]  i_be,
    input  wire [31:0] i_d,
    output wire [31:0] o_q
);
    reg [31:0] q_ff;
    integer    b;

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q_ff <= 32'h0000_0000;
        end else begin
            for (b = 0; b < 4; b = b + 1) begin
                if (i_be[b]) begin
                    q_ff[b*8 +: 8] <= i_d[b*8 +: 8];
                end
            end
        end
    end

    assign o_q = q_ff;
endmodule

`default_nettype wire

// ==== isoio_dbnc.v ====
`include "isoio_regs.vh"
`default_nettype none

// debounce hold-off timer; restart pulse loads the selected length
module isoio_dbnc (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire        i_start,
    input  wire [2:0]  i_sel,
    output wire        o_busy
);
    reg  [`ISOIO_DLY_CNT_W-1:0] cnt_ff;
    wire [`ISOIO_DLY_CNT_W-1:0] base = `ISOIO_DLY1_CYC;

    // 256 us doubled per step; code 0 means no hold-off
    function [`ISOIO_DLY_CNT_W-1:0] span;
        input [2:0] sel;
        begin
            if (sel == 3'h0) begin
                span = {`ISOIO_DLY_CNT_W{1'b0}};
            end else begin
                span = base << (sel - 3'h1);
            end
        end
    endfunction

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= {`ISOIO_DLY_CNT_W{1'b0}};
        end else if (i_start) begin
            cnt_ff <= span(i_sel);
        end else if (cnt_ff != {`ISOIO_DLY_CNT_W{1'b0}}) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    assign o_busy = (cnt_ff != {`ISOIO_DLY_CNT_W{1'b0}});
endmodule

`default_nettype wire

// ==== isoio_top.v ====
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`include "isoio_regs.vh"
`default_nettype none

module isoio_top (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire [3:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [3:0]  i_avs_byteenable,
    input  wire [31:0] i_avs_writedata,
    output reg  [31:0] o_avs_readdata,
    output wire        o_avs_waitrequest,
    input  wire [31:0] i_field_in,
    output wire [31:0] o_field_out,
    output wire        o_fault_led,
    output wire        o_input_offline_n,
    output wire        o_output_offline_n
);
    localparam ST_IDLE = 2'd0;
    localparam ST_CAPT = 2'd1;
    localparam ST_DONE = 2'd2;

    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [7:0]  ctrl_ff;
    reg  [31:0] input_capture_latch_ff;
    reg  [31:0] out_test_ff;
    reg  [31:0] nxt_rdata;
    reg  [7:0]  nxt_ctrl;
    reg  [31:0] nxt_input_capture_latch;
    reg  [31:0] nxt_out_test;
    reg  [31:0] field_out_ff;
    reg  [31:0] nxt_field_out;
    reg         fault_led_ff;
    reg         input_offline_n_ff;
    reg         output_offline_n_ff;

    // one word index compared against one port offset
    function addr_hit;
        input [3:0] addr;
        input [3:0] ofs;
        begin
            addr_hit = (addr == ofs);
        end
    endfunction

    wire [31:0] in_test_q;
    wire [31:0] output_hold_register;
    wire        dbnc_busy;
    wire        req = i_avs_read | i_avs_write;
    wire        sel_ctrl = addr_hit(i_avs_address, `ISOIO_OFS_CTRL);
    wire        sel_in = addr_hit(i_avs_address, `ISOIO_OFS_IN);
    wire        sel_out = addr_hit(i_avs_address, `ISOIO_OFS_OUT);
    wire        rd_in = i_avs_read && sel_in;
    wire        rd_out = i_avs_read && sel_out;
    wire        wr_hit = i_avs_write && (state_ff == ST_IDLE);
    wire        wr_ctrl = wr_hit && sel_ctrl && i_avs_byteenable[1];
    wire        wr_in = wr_hit && sel_in;
    wire        wr_out = wr_hit && sel_out;
    wire [3:0]  be_in_test = wr_in ? i_avs_byteenable : 4'h0;
    wire [3:0]  be_out_hold = wr_out ? i_avs_byteenable : 4'h0;
    wire        capt_go = (state_ff == ST_CAPT) && rd_in;
    wire        out_go = (state_ff == ST_CAPT) && rd_out;
    wire        fresh = capt_go && !dbnc_busy;
    wire        in_on = ctrl_ff[`ISOIO_CTRL_IN_ON - 8];
    wire [2:0]  dly_sel = ctrl_ff[2:0];

    // expand the four byte enables into a bit mask
    function [31:0] bmask;
        input [3:0] be;
        begin
            bmask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    // three-phase handshake: idle, capture, answer
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (req) begin
                    nxt_state = ST_CAPT;
                end
            end
            ST_CAPT: begin
                nxt_state = ST_DONE;
            end
            ST_DONE: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // answer lands in ST_DONE, entered on the same edge that loads the latch
    assign o_avs_waitrequest = req && (state_ff != ST_DONE);

    // control byte; low byte of the word reads zero
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_ff <= `ISOIO_CTRL_RESET;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    always @* begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctrl) begin
            nxt_ctrl = i_avs_writedata[15:8];
        end
    end

    // status pins straight from flops, loaded with the control byte
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            fault_led_ff <= 1'b1;
            input_offline_n_ff <= 1'b0;
            output_offline_n_ff <= 1'b0;
        end else begin
            fault_led_ff <= ~nxt_ctrl[`ISOIO_CTRL_FAULT_N - 8];
            input_offline_n_ff <= nxt_ctrl[`ISOIO_CTRL_IN_ON - 8];
            output_offline_n_ff <= nxt_ctrl[`ISOIO_CTRL_OUT_ON - 8];
        end
    end

    // input test registers at the input port address
    isoio_latch u_in_test (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_be  (be_in_test),
        .i_d   (i_avs_writedata),
        .o_q   (in_test_q)
    );

    // output hold registers at the output port address
    isoio_latch u_out_hold (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_be  (be_out_hold),
        .i_d   (i_avs_writedata),
        .o_q   (output_hold_register)
    );

    isoio_dbnc u_dbnc (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_start (fresh && in_on),
        .i_sel   (dly_sel),
        .o_busy  (dbnc_busy)
    );

    // test data bypass the hold-off so a test write shows whenever the input is offline
    always @* begin
        nxt_input_capture_latch = input_capture_latch_ff;
        if (capt_go) begin
            if (!in_on) begin
                nxt_input_capture_latch = in_test_q;
            end else if (!dbnc_busy) begin
                nxt_input_capture_latch = i_field_in;
            end
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            input_capture_latch_ff <= 32'h0000_0000;
        end else begin
            input_capture_latch_ff <= nxt_input_capture_latch;
        end
    end

    always @* begin
        nxt_out_test = out_test_ff;
        if (out_go) begin
            nxt_out_test = output_hold_register;
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            out_test_ff <= 32'h0000_0000;
        end else begin
            out_test_ff <= nxt_out_test;
        end
    end

    // outputs follow the hold word on the same edge, forced off while offline
    always @* begin
        nxt_field_out = output_hold_register;
        if (wr_out) begin
            nxt_field_out = (output_hold_register & ~bmask(i_avs_byteenable))
                          | (i_avs_writedata & bmask(i_avs_byteenable));
        end
        if (!nxt_ctrl[`ISOIO_CTRL_OUT_ON - 8]) begin
            nxt_field_out = 32'h0000_0000;
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            field_out_ff <= 32'h0000_0000;
        end else begin
            field_out_ff <= nxt_field_out;
        end
    end

    // read mux; unselected byte lanes return zero
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (i_avs_address)
            `ISOIO_OFS_ID: begin
                nxt_rdata = {`ISOIO_ID_VALUE, 16'h0000};
            end
            `ISOIO_OFS_CTRL: begin
                nxt_rdata = {16'h0000, ctrl_ff, 8'h00};
            end
            `ISOIO_OFS_IN: begin
                // the word being latched now, so a read returns its own capture
                nxt_rdata = nxt_input_capture_latch;
            end
            `ISOIO_OFS_OUT: begin
                nxt_rdata = nxt_out_test;
            end
            default: begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
        nxt_rdata = nxt_rdata & bmask(i_avs_byteenable);
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if ((state_ff == ST_CAPT) && i_avs_read) begin
            o_avs_readdata <= nxt_rdata;
        end
    end

    assign o_field_out = field_out_ff;
    assign o_fault_led = fault_led_ff;
    assign o_input_offline_n = input_offline_n_ff;
    assign o_output_offline_n = output_offline_n_ff;
endmodule

`default_nettype wire

// ==== isoio_monitor.sv ====
`default_nettype none
module isoio_monitor (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [3:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic [31:0] o_field_out,
    input wire logic        o_fault_led,
    input wire logic        o_input_offline_n,
    input wire logic        o_output_offline_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic done   = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
    wire logic ctl_wr = done && i_avs_write && i_avs_address == 4'h1 && i_avs_byteenable[1];
    wire logic out_wr = done && i_avs_write && i_avs_address == 4'h3 && i_avs_byteenable == 4'hf;
    wire logic out_rd = done && i_avs_read && i_avs_address == 4'h3 && i_avs_byteenable == 4'hf;
    sequence req_start;
        $rose(i_avs_read || i_avs_write);
    endsequence
    sequence two_waits;
        o_avs_waitrequest ##1 o_avs_waitrequest ##1 !o_avs_waitrequest;
    endsequence
    wait_two_a: assert property (req_start |-> two_waits)
        else $error("answer not on third edge");
    led_pol_a: assert property (ctl_wr |-> o_fault_led == !i_avs_writedata[15])
        else $error("lamp level wrong");
    in_state_a: assert property (ctl_wr |-> o_input_offline_n == i_avs_writedata[13])
        else $error("input mode wrong");
    out_state_a: assert property (ctl_wr |-> o_output_offline_n == i_avs_writedata[14])
        else $error("output mode wrong");
    out_gate_a: assert property (!o_output_offline_n |-> o_field_out == 32'h0)
        else $error("output on while offline");
    out_drive_a: assert property (out_wr && o_output_offline_n |-> o_field_out == i_avs_writedata)
        else $error("output not driven");
    out_mirror_a: assert property (out_rd && o_output_offline_n |-> o_avs_readdata == o_field_out)
        else $error("readback differs");
    rd_steady_a: assert property (!i_avs_read && !$past(i_avs_read) |-> $stable(o_avs_readdata))
        else $error("read data moved");
endmodule
bind isoio_top isoio_monitor isoio_monitor_inst (.*);
`default_nettype wire

// ==== isoio_field_model.sv ====
`default_nettype none
module isoio_field_model (
    input  wire logic        i_clk,
    input  wire logic [31:0] i_level,
    output var  logic [31:0] o_field_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_field_in = 32'h0;
    // conducting coupler shows a one; registered so levels move only on a rising clock edge
    always @(posedge i_clk) o_field_in <= i_level;
endmodule
`default_nettype wire

// ==== tb.sv ====
`include "isoio_regs.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [3:0]  i_avs_address = 4'h0;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [3:0]  i_avs_byteenable = 4'h0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [31:0] fld = 32'h0;
    logic [31:0] q;
    wire  [31:0] o_avs_readdata, i_field_in, o_field_out;
    wire         o_avs_waitrequest, o_fault_led, o_input_offline_n, o_output_offline_n;
    int          err_total = 0;
    int          checked = 0;
    always #4 i_clk = ~i_clk;
    isoio_top isoio_top_inst (.*);
    isoio_field_model isoio_field_model_inst (.i_clk(i_clk), .i_level(fld), .o_field_in(i_field_in));
    task automatic report_and_stop();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] b, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_avs_read <= !w;
        i_avs_write <= w;
        i_avs_address <= a;
        i_avs_byteenable <= b;
        i_avs_writedata <= d;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 20);
        q = o_avs_readdata;
        if (o_avs_waitrequest !== 1'b0) begin
            err_total++;
            report_and_stop();
        end
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 4'hf, 32'h0);
        chk(q, exp);
    endtask
    task automatic t_reset();
        rdchk(4'h1, 32'h0);
        chk({29'h0, o_fault_led, o_input_offline_n, o_output_offline_n}, 32'h4);
        rdchk(4'h9, 32'h0);
        rdchk(`ISOIO_OFS_ID, {`ISOIO_ID_VALUE, 16'h0000});
    endtask
    task automatic t_test();
        fld <= 32'h1234_5678;
        bus(1'b1, 4'h2, 4'hf, 32'hdead_beef);
        rdchk(4'h2, 32'hdead_beef);
        bus(1'b1, 4'h3, 4'hf, 32'ha5a5_0f0f);
        chk(o_field_out, 32'h0);
        rdchk(4'h3, 32'ha5a5_0f0f);
        bus(1'b1, 4'h3, 4'h2, 32'h0000_3c00);
        rdchk(4'h3, 32'ha5a5_3c0f);
    endtask
    task automatic t_online();
        bus(1'b1, 4'h1, 4'h2, 32'h0000_f800);
        chk({29'h0, o_fault_led, o_input_offline_n, o_output_offline_n}, 32'h3);
        chk(o_field_out, 32'ha5a5_3c0f);
        rdchk(4'h1, 32'h0000_f800);
        rdchk(4'h2, 32'h1234_5678);
        fld <= 32'h8765_4321;
        rdchk(4'h2, 32'h8765_4321);
        bus(1'b1, 4'h3, 4'hf, 32'h0ff0_1234);
        rdchk(4'h3, 32'h0ff0_1234);
    endtask
    task automatic t_debounce();
        bus(1'b1, 4'h1, 4'h2, 32'h0000_e100);
        rdchk(4'h2, 32'h8765_4321);
        fld <= 32'h0f0f_0f0f;
        rdchk(4'h2, 32'h8765_4321);
        repeat (`ISOIO_DLY1_CYC) @(posedge i_clk);
        rdchk(4'h2, 32'h0f0f_0f0f);
        bus(1'b0, 4'h2, 4'h1, 32'h0);
        chk(q, 32'h0000_000f);
    endtask
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_test();
        t_online();
        t_debounce();
        report_and_stop();
    end
endmodule
`default_nettype wire
